// *** hdl/jip_port.sv ***
`timescale 1ns/1ps
`include "jip_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - No boundary scan; default bypass instruction
// - Blank part: standard pins enabled for test
// - Pins inputs until enable command received
// - Enable is OR of four sources
// - Any reset clears software enable bit
// - Extension pins enabled together by command
// - Error pin low on failed erase/program
// - Status pin high read, low busy
// - Extension pins open-drain by default
// - Delivered: config bits zero, memory erased
//////////////////////////////////////////////////////////////////////////////
module jip_port (
   input wire logic clock,
   input wire logic resetn,
   input wire logic cfg_dedicated_pins,
   input wire logic cfg_programmed,
   input wire logic cable_port_enable,
   input wire logic sw_enable_wr,
   input wire logic sw_enable_val,
   input wire jip_pkg::jip_pins_s pins_in,
   input wire jip_pkg::jip_flash_s flash_in,
   output logic port_enabled,
   output logic sw_enable,
   output logic tdo_out,
   output logic tdo_oe,
   output logic isp_flash_status_pin_out,
   output logic isp_flash_status_pin_oe,
   output logic isp_flash_error_pin_out,
   output logic isp_flash_error_pin_oe,
   output logic ext_enabled,
   output logic channel_active,
   output logic [`JIP_IR_W-1:0] instr
);
   import jip_pkg::*;
   //////////////////////////////////////////////////////////////////////////
   logic sw_en_r;
   logic port_en_r;
   logic active_r;
   logic ext_r;
   logic push_pull_r;
   logic tck_d_r;
   logic tdo_r;
   logic tdo_oe_r;
   logic st_out_r;
   logic st_oe_r;
   logic er_out_r;
   logic er_oe_r;
   logic bypass_r;
   logic [`JIP_IR_W-1:0] ir_sh_r;
   logic [`JIP_IR_W-1:0] ir_r;
   jip_tap_e state_r;
   jip_tap_e state_nxt;
   jip_pins_s pins_s;

   jip_sync #(.W(3)) u_sync (
      .clock(clock),
      .resetn(resetn),
      .d(pins_in),
      .q(pins_s)
   );

   // Blank part (not programmed) behaves as dedicated pins
   wire en_nxt = cfg_dedicated_pins | ~cfg_programmed | cable_port_enable
      | sw_en_r;
   wire tck_rise = pins_s.tck & ~tck_d_r;
   wire tck_fall = ~pins_s.tck & tck_d_r;
   wire tms = pins_s.tms;
   wire in_shift_dr = state_r == JIP_SH_DR;
   wire in_shift_ir = state_r == JIP_SH_IR;
   wire sel_bypass = ~active_r | (ir_r == `JIP_INS_BYPASS);
   wire tdo_nxt = in_shift_ir ? ir_sh_r[0] : bypass_r;
   wire cmd_en = ir_r == `JIP_INS_ISP_EN;
   wire cmd_en_ext = ir_r == `JIP_INS_ISP_EN_EXT;
   wire cmd_off = ir_r == `JIP_INS_ISP_OFF;
   wire upd_ir = tck_rise & (state_r == JIP_UPD_IR);
   // Error active low on failure; status high in read mode
   wire err_lvl = ~flash_in.fail;
   wire st_lvl = flash_in.ready;

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      unique case (state_r)
         JIP_TLR: state_nxt = tms ? JIP_TLR : JIP_RTI;
         JIP_RTI: state_nxt = tms ? JIP_SEL_DR : JIP_RTI;
         JIP_SEL_DR: state_nxt = tms ? JIP_SEL_IR : JIP_CAP_DR;
         JIP_CAP_DR: state_nxt = tms ? JIP_EX1_DR : JIP_SH_DR;
         JIP_SH_DR: state_nxt = tms ? JIP_EX1_DR : JIP_SH_DR;
         JIP_EX1_DR: state_nxt = tms ? JIP_UPD_DR : JIP_PA_DR;
         JIP_PA_DR: state_nxt = tms ? JIP_EX2_DR : JIP_PA_DR;
         JIP_EX2_DR: state_nxt = tms ? JIP_UPD_DR : JIP_SH_DR;
         JIP_UPD_DR: state_nxt = tms ? JIP_SEL_DR : JIP_RTI;
         JIP_SEL_IR: state_nxt = tms ? JIP_TLR : JIP_CAP_IR;
         JIP_CAP_IR: state_nxt = tms ? JIP_EX1_IR : JIP_SH_IR;
         JIP_SH_IR: state_nxt = tms ? JIP_EX1_IR : JIP_SH_IR;
         JIP_EX1_IR: state_nxt = tms ? JIP_UPD_IR : JIP_PA_IR;
         JIP_PA_IR: state_nxt = tms ? JIP_EX2_IR : JIP_PA_IR;
         JIP_EX2_IR: state_nxt = tms ? JIP_UPD_IR : JIP_SH_IR;
         JIP_UPD_IR: state_nxt = tms ? JIP_SEL_DR : JIP_RTI;
         default: state_nxt = JIP_TLR;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sw_en_r <= 1'b0;
         port_en_r <= 1'b0;
         tck_d_r <= 1'b0;
      end else begin
         if (sw_enable_wr) begin
            sw_en_r <= sw_enable_val;
         end
         port_en_r <= en_nxt;
         tck_d_r <= pins_s.tck;
      end
   end

   // TAP advances on test-clock rising edges while the port is enabled
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= JIP_TLR;
      end else if (!port_en_r) begin
         state_r <= JIP_TLR;
      end else if (tck_rise) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ir_sh_r <= `JIP_IR_RESET;
         ir_r <= `JIP_INS_BYPASS;
         bypass_r <= 1'b0;
      end else if (!port_en_r || state_r == JIP_TLR) begin
         ir_r <= `JIP_INS_BYPASS;
      end else if (tck_rise) begin
         if (state_r == JIP_CAP_IR) begin
            ir_sh_r <= `JIP_IR_CAPTURE;
         end else if (in_shift_ir) begin
            ir_sh_r <= {pins_s.tdi, ir_sh_r[`JIP_IR_W-1:1]};
         end else if (state_r == JIP_UPD_IR) begin
            ir_r <= ir_sh_r;
         end
         if (state_r == JIP_CAP_DR) begin
            bypass_r <= 1'b0;
         end else if (in_shift_dr) begin
            bypass_r <= pins_s.tdi;
         end
      end
   end

   // Enabling command activates the channel and optionally the extension pair
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         active_r <= 1'b0;
         ext_r <= 1'b0;
         push_pull_r <= `JIP_CFG_PUSH_PULL_RST;
      end else if (!port_en_r || (cmd_off && !upd_ir)) begin
         active_r <= 1'b0;
         ext_r <= 1'b0;
      end else if (upd_ir && (ir_sh_r == `JIP_INS_ISP_EN)) begin
         active_r <= 1'b1;
         ext_r <= 1'b0;
      end else if (upd_ir && (ir_sh_r == `JIP_INS_ISP_EN_EXT)) begin
         active_r <= 1'b1;
         ext_r <= 1'b1;
         push_pull_r <= pins_s.tms;
      end
   end

   // TDO changes on falling test clock, driven only in shift once active
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tdo_r <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else if (tck_fall) begin
         tdo_r <= sel_bypass & in_shift_dr ? bypass_r : tdo_nxt;
         tdo_oe_r <= active_r & port_en_r & (in_shift_dr | in_shift_ir);
      end else if (!port_en_r || !active_r) begin
         tdo_oe_r <= 1'b0;
      end
   end

   // Open-drain drives only the low level; push-pull drives both
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_out_r <= 1'b0;
         st_oe_r <= 1'b0;
         er_out_r <= 1'b0;
         er_oe_r <= 1'b0;
      end else begin
         st_out_r <= st_lvl;
         er_out_r <= err_lvl;
         st_oe_r <= ext_r & (push_pull_r | ~st_lvl);
         er_oe_r <= ext_r & (push_pull_r | ~err_lvl);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   assign port_enabled = port_en_r;
   assign sw_enable = sw_en_r;
   assign tdo_out = tdo_r;
   assign tdo_oe = tdo_oe_r;
   assign isp_flash_status_pin_out = st_out_r;
   assign isp_flash_status_pin_oe = st_oe_r;
   assign isp_flash_error_pin_out = er_out_r;
   assign isp_flash_error_pin_oe = er_oe_r;
   assign ext_enabled = ext_r;
   assign channel_active = active_r;
   assign instr = ir_r;
   // Commands other than bypass/enable/off act as bypass
   wire unused_ok = cmd_en | cmd_en_ext;
endmodule : jip_port

// *** hdl/jip_cfg.svh ***
`ifndef JIP_CFG_SVH
`define JIP_CFG_SVH
// Instruction register layout and codes
`define JIP_IR_W 4
`define JIP_IR_RESET 4'hf
`define JIP_IR_CAPTURE 4'h1
`define JIP_INS_BYPASS 4'hf
`define JIP_INS_ISP_EN 4'h2
`define JIP_INS_ISP_EN_EXT 4'h3
`define JIP_INS_ISP_OFF 4'h4
// Option bits after the enabling command: 1 = push-pull
`define JIP_CFG_PUSH_PULL_RST 1'b0
`endif

// *** hdl/jip_pkg.sv ***
package jip_pkg;
   typedef enum logic [15:0] {
      JIP_TLR = 16'h0001, JIP_RTI = 16'h0002, JIP_SEL_DR = 16'h0004,
      JIP_CAP_DR = 16'h0008, JIP_SH_DR = 16'h0010, JIP_EX1_DR = 16'h0020,
      JIP_PA_DR = 16'h0040, JIP_EX2_DR = 16'h0080, JIP_UPD_DR = 16'h0100,
      JIP_SEL_IR = 16'h0200, JIP_CAP_IR = 16'h0400, JIP_SH_IR = 16'h0800,
      JIP_EX1_IR = 16'h1000, JIP_PA_IR = 16'h2000, JIP_EX2_IR = 16'h4000,
      JIP_UPD_IR = 16'h8000
   } jip_tap_e;
   typedef struct packed {
      logic tms;
      logic tck;
      logic tdi;
   } jip_pins_s;
   typedef struct packed {
      logic ready;
      logic fail;
   } jip_flash_s;
endpackage : jip_pkg

// *** hdl/jip_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; change accepted when stages two and three agree
module jip_sync #(
   parameter int W = 3
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   wire [W-1:0] agree = ~(s2_r ^ s3_r);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= (agree & s3_r) | (~agree & q_r);
      end
   end
   assign q = q_r;
endmodule : jip_sync

// *** bench/jip_port_chk.sv ***
`timescale 1ns/1ps
module jip_port_chk
   import jip_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic cfg_dedicated_pins,
   input wire logic cfg_programmed,
   input wire logic cable_port_enable,
   input wire logic sw_enable_wr,
   input wire logic sw_enable_val,
   input wire jip_pkg::jip_flash_s flash_in,
   input wire logic port_enabled,
   input wire logic sw_enable,
   input wire logic tdo_oe,
   input wire logic isp_flash_status_pin_out,
   input wire logic isp_flash_status_pin_oe,
   input wire logic isp_flash_error_pin_out,
   input wire logic isp_flash_error_pin_oe,
   input wire logic ext_enabled,
   input wire logic channel_active
);
   wire any_src = cfg_dedicated_pins | cable_port_enable | ~cfg_programmed | sw_enable;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   a_enable_or_src: assert property ($past(resetn) |-> port_enabled == $past(any_src))
      else $error("enable not OR of sources");
   a_sw_write: assert property (sw_enable_wr |=> sw_enable == $past(sw_enable_val))
      else $error("software bit not written");
   a_sw_reset_clear: assert property ($rose(resetn) |-> !sw_enable)
      else $error("software bit survives reset");
   a_tdo_needs_channel: assert property (tdo_oe |-> channel_active)
      else $error("data out driven without channel");
   a_disabled_quiet: assert property (!port_enabled [*3] |-> !channel_active && !tdo_oe)
      else $error("disabled port still active");
   a_ext_off_quiet: assert property (!$past(ext_enabled) |-> !isp_flash_status_pin_oe
      && !isp_flash_error_pin_oe)
      else $error("extension pin driven while off");
   a_status_follows: assert property ($past(ext_enabled) |-> isp_flash_status_pin_out ==
      $past(flash_in.ready) && (isp_flash_status_pin_oe || isp_flash_status_pin_out))
      else $error("status pin wrong");
   a_error_follows: assert property ($past(ext_enabled) |-> isp_flash_error_pin_out ==
      !$past(flash_in.fail) && (isp_flash_error_pin_oe || isp_flash_error_pin_out))
      else $error("error pin wrong");
endmodule : jip_port_chk
bind jip_port jip_port_chk chk (.clock, .resetn, .cfg_dedicated_pins, .cfg_programmed,
   .cable_port_enable, .sw_enable_wr, .sw_enable_val, .flash_in, .port_enabled, .sw_enable,
   .tdo_oe, .isp_flash_status_pin_out, .isp_flash_status_pin_oe, .isp_flash_error_pin_out,
   .isp_flash_error_pin_oe, .ext_enabled, .channel_active);

// *** bench/jip_ctl.sv ***
`timescale 1ns/1ps
module jip_ctl
   import jip_pkg::*;
(
   input wire logic clock,
   input wire logic tdo_out,
   input wire logic tdo_oe,
   output jip_pkg::jip_pins_s pins
);
   initial pins = 3'h0;
   // Test clock rests low between frames; data toggles once its hold is over
   task automatic seq(input logic [15:0] tms, input logic [15:0] tdi, input int n,
      output logic [15:0] tdo);
      tdo = '0;
      for (int i = 0; i < n; i++) begin
         pins.tms = tms[i];
         pins.tdi = tdi[i];
         repeat (6) @(negedge clock);
         tdo[i] = tdo_oe ? tdo_out : 1'b1; // Pull-up when undriven
         pins.tck = 1'b1;
         repeat (4) @(negedge clock);
         pins.tck = 1'b0;
         pins.tdi = ~tdi[i];
      end
   endtask : seq
endmodule : jip_ctl

// *** bench/tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
   $display("BAD %0t %h %h", $time, a, e); end end
module tb;
   import jip_pkg::*;
   logic clock = 0, resetn = 0, ded = 0, prog = 0, cab = 0, wr = 0, val = 0;
   jip_flash_s fl = '0;
   jip_pins_s pins;
   logic pe, swe, to, toe, so, soe, eo, eoe, ext, act;
   logic [3:0] ins;
   logic [15:0] r;
   int n_fail = 0, compares = 0, cyc = 0;
   always #4 clock = ~clock;
   jip_port dut (.clock, .resetn, .cfg_dedicated_pins(ded), .cfg_programmed(prog),
      .cable_port_enable(cab), .sw_enable_wr(wr), .sw_enable_val(val), .pins_in(pins),
      .flash_in(fl), .port_enabled(pe), .sw_enable(swe), .tdo_out(to), .tdo_oe(toe),
      .isp_flash_status_pin_out(so), .isp_flash_status_pin_oe(soe),
      .isp_flash_error_pin_out(eo), .isp_flash_error_pin_oe(eoe), .ext_enabled(ext),
      .channel_active(act), .instr(ins));
   jip_ctl ctl (.clock, .tdo_out(to), .tdo_oe(toe), .pins);
   task automatic swr(input logic v);
      @(negedge clock);
      wr = 1;
      val = v;
      @(negedge clock);
      wr = 0;
   endtask : swr
   task automatic ir(input logic [3:0] c);
      ctl.seq(16'h183, {6'h0, c, 4'h0}, 10, r);
      repeat (6) @(negedge clock);
   endtask : ir
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         report_and_stop;
      end
   end
   initial begin
      repeat (12) @(negedge clock);
      resetn = 1;
      @(negedge clock);
      @(negedge clock);
      `CHK({pe, swe, ins}, 6'h2f)
      for (int i = 0; i < 4; i++) begin
         prog = i != 0;
         ded = i == 1;
         cab = i == 2;
         swr(i == 3);
         repeat (2) @(negedge clock);
         `CHK(pe, 1'b1)
         prog = 1;
         ded = 0;
         cab = 0;
         swr(0);
         repeat (2) @(negedge clock);
         `CHK(pe, 1'b0)
      end
      swr(1);
      resetn = 0;
      @(negedge clock);
      resetn = 1;
      @(negedge clock);
      `CHK({swe, pe}, 2'b00)
      $display("test sources done");
      cab = 1;
      ctl.seq(16'h1f, 16'h0, 6, r);
      `CHK({toe, act}, 2'b00)
      ir(4'h2);
      `CHK({ins, act, ext}, 6'h0a)
      ir(4'h3);
      `CHK({r[7:4], ext}, 5'h03)
      fl = 2'b00;
      repeat (3) @(negedge clock);
      `CHK({so, soe, eo, eoe}, 4'b0110)
      fl = 2'b11;
      repeat (3) @(negedge clock);
      `CHK({so, soe, eo, eoe}, 4'b1001)
      ctl.seq(16'h383, {6'h0, 4'h3, 4'h0}, 10, r);
      repeat (6) @(negedge clock);
      `CHK({so, soe, eo, eoe}, 4'b1101)
      ctl.seq(16'h1f, 16'h0, 6, r);
      ir(4'h4);
      `CHK({act, ext}, 2'b00)
      ir(4'h2);
      `CHK({ins, act}, 5'h05)
      ir(4'hf);
      ctl.seq(16'h31, 16'h8, 7, r);
      `CHK(r[4:3], 2'b10)
      cab = 0;
      repeat (4) @(negedge clock);
      `CHK({pe, act, toe}, 3'h0)
      $display("test port done");
      report_and_stop;
   end
endmodule : tb
